// [adc_scan_defines.svh]
`ifndef ADC_SCAN_DEFINES_SVH
`define ADC_SCAN_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_SCAN_SELECT_LOW 4'h0
`define OFS_SCAN_SELECT_HIGH 4'h4
`define OFS_CONV_CONTROL 4'h8
`define OFS_SCAN_STATUS 4'hc

// Field positions
`define HIGH_CH16_BIT 0
`define HIGH_CH28_LSB 12
`define HIGH_CH30_MSB 14
`define CTRL_SCAN_ENABLE_BIT 15
`define STAT_ACTIVE_BIT 8

// Writable bits of the high select register: channel 16 and 30..28
`define HIGH_WRITE_MASK 16'h7001

// Reset values
`define SCAN_SELECT_LOW_RESET 16'h0000
`define SCAN_SELECT_HIGH_RESET 16'h0000
`define CONV_CONTROL_RESET 16'h0000

// Oscillator periods per instruction cycle, doze and multiplier off
`define OSC_PERIODS_PER_INSTR 2

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [adc_scan_pkg.sv]
package adc_scan_pkg;

	typedef enum logic {
		SCAN_IDLE,
		SCAN_RUN
	} scan_state_t;

	typedef struct packed {
		logic active;
		logic [4:0] channel;
	} scan_status_t;

endpackage

// [scan_channel_picker.sv]
module scan_channel_picker (
	input wire logic [30:0] mask,
	input wire logic [4:0] current,
	output logic any,
	output logic [4:0] first,
	output logic [4:0] next
);

	// Lowest set bit of v at or above index from; bit 5 of the result flags a hit
	function automatic logic [5:0] lowest_from(input logic [30:0] v, input logic [4:0] from);
		logic [5:0] result;
		result = 6'h00;
		for (int i = 30; i >= 0; i--) begin
			if (v[i] && (5'(i) >= from)) begin
				result = {1'b1, 5'(i)};
			end
		end
		return result;
	endfunction

	logic [5:0] above;
	logic [5:0] lowest;

	always_comb begin
		lowest = lowest_from(mask, 5'h00);
		above = (current == 5'h1e) ? 6'h00 : lowest_from(mask, current + 5'h01);
		any = lowest[5];
		first = lowest[4:0];
		// Ascending order, wrapping to the lowest selected channel
		next = above[5] ? above[4:0] : lowest[4:0];
	end

endmodule

// [adc_scan_select_and_clock.sv]
// What this block does
// - A set select bit includes its channel in the scan; a clear bit skips it.
// - Low register holds channels 15-0; high holds 16 at bit 0, 30-28 at 14-12.
// - High register bits 15 and 11-1 ignore writes and read zero.
// - Conversion clock period is instruction cycle times divider plus one.
// - Instruction cycle lasts two oscillator periods.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`include "adc_scan_defines.svh"

module adc_scan_select_and_clock
	import adc_scan_pkg::*;
#(
	parameter int ADDR_WIDTH = 4,
	parameter int DIVIDER_WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic conversion_done,
	output logic conversion_clock_tick,
	output logic [30:0] scan_mask,
	output logic [4:0] scan_channel,
	output logic scan_active
);

	if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin
		$error("ADDR_WIDTH must lie between 4 and 32");
	end
	if (DIVIDER_WIDTH < 1 || DIVIDER_WIDTH > 15) begin
		$error("DIVIDER_WIDTH must lie between 1 and 15");
	end

	function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [15:0] result;
		result = old;
		if (strb[0]) begin
			result[7:0] = data[7:0];
		end
		if (strb[1]) begin
			result[15:8] = data[15:8];
		end
		return result;
	endfunction

	function automatic logic mapped(input logic [ADDR_WIDTH-1:0] addr);
		logic [3:0] ofs;
		ofs = addr[3:0];
		return (addr[ADDR_WIDTH-1:2] <= (ADDR_WIDTH-2)'(3)) && (ofs[1:0] == 2'h0);
	endfunction

	// Register bus state
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [ADDR_WIDTH-1:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;

	// Software registers
	logic [15:0] scan_select_low, next_scan_select_low;
	logic [15:0] scan_select_high, next_scan_select_high;
	logic [15:0] conv_control, next_conv_control;

	// Clock derivation and sequencer
	logic [1:0] osc_count, next_osc_count;
	logic [DIVIDER_WIDTH-1:0] instr_count, next_instr_count;
	logic conv_tick, next_conv_tick;
	scan_state_t state, next_state;
	scan_status_t status, next_status;

	logic aw_fire, w_fire, have_aw, have_w, do_write;
	logic [ADDR_WIDTH-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [DIVIDER_WIDTH-1:0] divider;
	logic instr_tick;
	logic [30:0] mask;
	logic pick_any;
	logic [4:0] pick_first, pick_next;

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;

	assign divider = conv_control[DIVIDER_WIDTH-1:0];
	// Channels 27..17 do not exist and stay out of the scan
	assign mask = {scan_select_high[`HIGH_CH30_MSB:`HIGH_CH28_LSB], 11'h000,
		scan_select_high[`HIGH_CH16_BIT], scan_select_low};
	assign scan_mask = mask;
	assign scan_channel = status.channel;
	assign scan_active = status.active;
	assign conversion_clock_tick = conv_tick;

	scan_channel_picker picker (
		.mask(mask),
		.current(status.channel),
		.any(pick_any),
		.first(pick_first),
		.next(pick_next)
	);

	always_comb begin
		aw_fire = s_axi_awvalid && s_axi_awready;
		w_fire = s_axi_wvalid && s_axi_wready;
		have_aw = aw_held || aw_fire;
		have_w = w_held || w_fire;
		do_write = have_aw && have_w;
		wr_addr = aw_fire ? s_axi_awaddr : aw_addr;
		wr_data = w_fire ? s_axi_wdata : w_data;
		wr_strb = w_fire ? s_axi_wstrb : w_strb;
		next_aw_addr = aw_fire ? s_axi_awaddr : aw_addr;
		next_w_data = w_fire ? s_axi_wdata : w_data;
		next_w_strb = w_fire ? s_axi_wstrb : w_strb;
		next_aw_held = have_aw && !do_write;
		next_w_held = have_w && !do_write;
		next_bvalid = bvalid && !s_axi_bready;
		next_bresp = bresp;
		next_scan_select_low = scan_select_low;
		next_scan_select_high = scan_select_high;
		next_conv_control = conv_control;
		if (do_write) begin
			next_bvalid = 1'b1;
			next_bresp = mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
			if (mapped(wr_addr)) begin
				unique case (wr_addr[3:0])
					`OFS_SCAN_SELECT_LOW: begin
						next_scan_select_low = merge_lanes(scan_select_low, wr_data, wr_strb);
					end
					`OFS_SCAN_SELECT_HIGH: begin
						next_scan_select_high = merge_lanes(scan_select_high, wr_data, wr_strb)
							& `HIGH_WRITE_MASK;
					end
					`OFS_CONV_CONTROL: begin
						next_conv_control = merge_lanes(conv_control, wr_data, wr_strb)
							& {1'b1, 15'((16'h0001 << DIVIDER_WIDTH) - 16'h0001)};
					end
					default: begin
						// Status is read-only; writes are accepted and dropped
					end
				endcase
			end
		end
		next_rvalid = rvalid && !s_axi_rready;
		next_rresp = rresp;
		next_rdata = rdata;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			next_rdata = 32'h00000000;
			if (mapped(s_axi_araddr)) begin
				unique case (s_axi_araddr[3:0])
					`OFS_SCAN_SELECT_LOW: next_rdata = {16'h0000, scan_select_low};
					`OFS_SCAN_SELECT_HIGH: next_rdata = {16'h0000, scan_select_high};
					`OFS_CONV_CONTROL: next_rdata = {16'h0000, conv_control};
					default: begin
						next_rdata[`STAT_ACTIVE_BIT] = status.active;
						next_rdata[4:0] = status.channel;
					end
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= `RESP_OKAY;
			rdata <= 32'h00000000;
			scan_select_low <= `SCAN_SELECT_LOW_RESET;
			scan_select_high <= `SCAN_SELECT_HIGH_RESET;
			conv_control <= `CONV_CONTROL_RESET;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			scan_select_low <= next_scan_select_low;
			scan_select_high <= next_scan_select_high;
			conv_control <= next_conv_control;
		end
	end

	// Divider changes take effect at the next wrap or at once if the count is past it
	always_comb begin
		instr_tick = (osc_count == 2'(`OSC_PERIODS_PER_INSTR - 1));
		next_osc_count = instr_tick ? 2'h0 : osc_count + 2'h1;
		next_instr_count = instr_count;
		next_conv_tick = 1'b0;
		if (instr_tick) begin
			if (instr_count >= divider) begin
				next_instr_count = '0;
				next_conv_tick = 1'b1;
			end else begin
				next_instr_count = instr_count + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_count <= 2'h0;
			instr_count <= '0;
			conv_tick <= 1'b0;
		end else begin
			osc_count <= next_osc_count;
			instr_count <= next_instr_count;
			conv_tick <= next_conv_tick;
		end
	end

	// A mask cleared mid-scan stops the scan rather than parking on a skipped channel
	always_comb begin
		next_state = state;
		next_status = status;
		unique case (state)
			SCAN_IDLE: begin
				next_status.active = 1'b0;
				if (conv_control[`CTRL_SCAN_ENABLE_BIT] && pick_any) begin
					next_state = SCAN_RUN;
					next_status.active = 1'b1;
					next_status.channel = pick_first;
				end
			end
			SCAN_RUN: begin
				if (!conv_control[`CTRL_SCAN_ENABLE_BIT] || !pick_any) begin
					next_state = SCAN_IDLE;
					next_status.active = 1'b0;
				end else if (conversion_done || !mask[status.channel]) begin
					next_status.channel = pick_next;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= SCAN_IDLE;
			status <= '0;
		end else begin
			state <= next_state;
			status <= next_status;
		end
	end

endmodule

// [adc_scan_select_and_clock_assertions.sv]
module adc_scan_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic conversion_done,
	input wire logic conversion_clock_tick,
	input wire logic [30:0] scan_mask,
	input wire logic [4:0] scan_channel,
	input wire logic scan_active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_mask_unused_zero: assert property (scan_mask[27:17] == 11'h000)
		else $error("unused mask bits set");
	a_tick_one_cycle: assert property (conversion_clock_tick |=> !conversion_clock_tick)
		else $error("tick too long");
	a_active_on_selected: assert property (scan_active && $past(scan_active)
		&& $stable(scan_mask) |-> scan_mask[scan_channel])
		else $error("scan on skipped channel");
	a_empty_mask_idle: assert property (scan_mask == 31'h0 |=> !scan_active)
		else $error("scan with empty mask");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_held_off: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	c_tick: cover property (conversion_clock_tick);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_advance: cover property (conversion_done && scan_active);
endmodule

bind adc_scan_select_and_clock adc_scan_checker i_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.conversion_done(conversion_done),
	.conversion_clock_tick(conversion_clock_tick),
	.scan_mask(scan_mask),
	.scan_channel(scan_channel),
	.scan_active(scan_active)
);

// [adc_scan_select_and_clock_tb_top.sv]
module adc_scan_select_and_clock_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, conversion_done = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, conversion_clock_tick, scan_active;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [30:0] scan_mask;
	logic [4:0] scan_channel;
	int miscompares = 0, total_checks = 0, cycles = 0;
	adc_scan_select_and_clock i_dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.conversion_done(conversion_done),
		.conversion_clock_tick(conversion_clock_tick),
		.scan_mask(scan_mask),
		.scan_channel(scan_channel),
		.scan_active(scan_active)
	);
	initial forever #25 aclk = ~aclk;
	// Bound well above the whole sequence
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			end_sim;
		end
	end
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Readies sampled at the falling edge, so the decision never races the rising one
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, wd, s1, s2;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ad && wd)) begin
			@(negedge aclk);
			s1 = s_axi_awready;
			s2 = s_axi_wready;
			@(posedge aclk);
			if (s1 && !ad) begin
				ad = 1;
				s_axi_awvalid <= 0;
			end
			if (s2 && !wd) begin
				wd = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge aclk);
		s_axi_bready <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		logic s1;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(negedge aclk);
			s1 = s_axi_arready;
			@(posedge aclk);
		end while (!s1);
		s_axi_arvalid <= 0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		@(posedge aclk);
		s_axi_rready <= 0;
	endtask
	task t_regs;
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h4, 32'h0, 2'h0);
		rd(4'h8, 32'h0, 2'h0);
		wr(4'h0, 32'hffffffff, 2'h0);
		rd(4'h0, 32'h0000ffff, 2'h0);
		wr(4'h4, 32'h0000ffff, 2'h0);
		rd(4'h4, 32'h00007001, 2'h0);
		chk({1'b0, scan_mask}, 32'h7001ffff);
		// Upper lane only, so the low byte must survive
		s_axi_wstrb <= 4'h2;
		wr(4'h0, 32'h0000ab00, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(4'h0, 32'h0000abff, 2'h0);
		wr(4'h2, 32'h0, 2'h2);
		rd(4'h2, 32'h0, 2'h2);
	endtask
	task t_clk(input int dv);
		int n;
		wr(4'h8, dv, 2'h0);
		do @(negedge aclk); while (conversion_clock_tick !== 1'b1);
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (conversion_clock_tick !== 1'b1);
		chk(n, 2 * (dv + 1));
	endtask
	task t_scan;
		int exp_ch[4] = '{2, 28, 0, 2};
		wr(4'h0, 32'h5, 2'h0);
		wr(4'h4, 32'h1000, 2'h0);
		wr(4'h8, 32'h8000, 2'h0);
		rd(4'h8, 32'h00008000, 2'h0);
		@(negedge aclk);
		chk(scan_active, 1);
		chk(scan_channel, 0);
		rd(4'hc, 32'h00000100, 2'h0);
		foreach (exp_ch[i]) begin
			@(posedge aclk);
			conversion_done <= 1;
			@(posedge aclk);
			conversion_done <= 0;
			@(negedge aclk);
			chk(scan_channel, exp_ch[i]);
		end
		// Deselecting the current channel moves the scan on without a pulse
		wr(4'h0, 32'h1, 2'h0);
		@(negedge aclk);
		chk(scan_channel, 28);
		wr(4'h8, 32'h0, 2'h0);
		@(negedge aclk);
		chk(scan_active, 0);
		// Channel holds its last value once idle; status ignores writes
		rd(4'hc, 32'h0000001c, 2'h0);
		wr(4'hc, 32'h0000ffff, 2'h0);
		rd(4'hc, 32'h0000001c, 2'h0);
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		t_regs;
		t_clk(0);
		t_clk(5);
		t_scan;
		end_sim;
	end
endmodule
